/* hdl/irq_clear_pending_bank1.sv */
// Functional notes
// - bit n maps to source n, 30:14, 12:0
// - writing one clears that source's pending state
// - clear ignored while the source is serviced
// - writing zero changes no pending state
// - read returns live pending state per bit
// - force sets pending unless disabled
`timescale 1ns/1ps
`default_nettype none
module irq_clear_pending_bank1
    import irq_pending_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [31:0]       irq_req,
    input  wire logic [31:0]       irq_active,
    input  wire logic [31:0]       irq_taken,
    output var  logic [31:0]       pending_out
);
    logic [ADDR_W-1:0] waddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_held_q;
    logic              w_held_q;
    logic              aw_held_d;
    logic              w_held_d;
    logic [ADDR_W-1:0] raddr_q;
    logic              ar_held_q;
    logic              ar_held_d;
    logic              wr_do;
    logic              rd_do;
    logic [31:0]       strb_mask;
    logic [31:0]       wr_bits;
    logic [31:0]       clear_vec;
    logic [31:0]       force_vec;
    logic [31:0]       enable_q;
    logic [31:0]       pend;
    logic [31:0]       rd_value;
    logic              rd_hit;
    logic              wr_hit;

    function automatic logic match(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return {a[7:2], 2'b00} == ofs;
    endfunction : match

    assign wr_do     = aw_held_q && w_held_q && !s_axi_bvalid;
    assign rd_do     = ar_held_q && !s_axi_rvalid;
    assign strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_bits   = wdata_q & strb_mask;
    assign wr_hit    = match(waddr_q, PEND_CLEAR_OFS) || match(waddr_q, PEND_FORCE_OFS)
                       || match(waddr_q, ENABLE_OFS) || match(waddr_q, ACTIVE_OFS);
    // only ones act; reserved bits are masked off
    assign clear_vec = (wr_do && match(waddr_q, PEND_CLEAR_OFS)) ? wr_bits & IMPL_MASK
                                                                  : 32'h0000_0000;
    assign force_vec = (wr_do && match(waddr_q, PEND_FORCE_OFS)) ? wr_bits & IMPL_MASK
                                                                  : 32'h0000_0000;

    // address/data channels taken in either order
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        ar_held_d = ar_held_q;
        if (wr_do) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
        end
        if (rd_do) begin
            ar_held_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            ar_held_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            ar_held_q     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            aw_held_q     <= aw_held_d;
            w_held_q      <= w_held_d;
            ar_held_q     <= ar_held_d;
            s_axi_awready <= !aw_held_d;
            s_axi_wready  <= !w_held_d;
            s_axi_arready <= !ar_held_d;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
            raddr_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                raddr_q <= s_axi_araddr;
            end
        end
    end

    // write response
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= ENABLE_RESET;
        end else if (wr_do && match(waddr_q, ENABLE_OFS)) begin
            enable_q <= (enable_q & ~strb_mask) | (wr_bits & IMPL_MASK);
        end
    end

    // one cell per implemented source; holes stay zero
    for (genvar n = 0; n < NUM_SRC; n++) begin : g_src
        if (IMPL_MASK[n]) begin : g_impl
            pending_cell u_cell (
                .ref_clk   (ref_clk),
                .resetn    (resetn),
                .enable    (enable_q[n]),
                .hw_req    (irq_req[n]),
                .sw_force  (force_vec[n]),
                .sw_clear  (clear_vec[n]),
                .active    (irq_active[n]),
                .taken     (irq_taken[n]),
                .pending_q (pend[n])
            );
        end else begin : g_hole
            assign pend[n] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pending_out <= PEND_RESET;
        end else begin
            pending_out <= pend;
        end
    end

    always_comb begin
        rd_hit   = 1'b1;
        rd_value = 32'h0000_0000;
        if (match(raddr_q, PEND_CLEAR_OFS) || match(raddr_q, PEND_FORCE_OFS)) begin
            rd_value = pend & IMPL_MASK;
        end else if (match(raddr_q, ENABLE_OFS)) begin
            rd_value = enable_q;
        end else if (match(raddr_q, ACTIVE_OFS)) begin
            rd_value = irq_active & IMPL_MASK;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    sequence clear_write_s;
        wr_do && match(waddr_q, PEND_CLEAR_OFS);
    endsequence

    sequence force_write_s;
        wr_do && match(waddr_q, PEND_FORCE_OFS);
    endsequence

    sequence pend_read_s;
        rd_do && match(raddr_q, PEND_CLEAR_OFS);
    endsequence

    clear_effect_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        clear_write_s |=> (pend & $past(clear_vec & ~irq_active & ~irq_req & ~force_vec))
                          == 32'h0000_0000)
        else $error("written one did not clear pending");

    zero_write_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        clear_write_s |=> ($past(pend & ~clear_vec & ~irq_taken) & ~pend) == 32'h0000_0000)
        else $error("zero write dropped a pending bit");

    serviced_hold_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        clear_write_s |=> ($past(pend & irq_active & ~irq_taken) & ~pend) == 32'h0000_0000)
        else $error("clear acted on serviced source");

    reserved_zero_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        pend[31] == 1'b0 && pend[13] == 1'b0
        && pending_out[31] == 1'b0 && pending_out[13] == 1'b0)
        else $error("reserved bit became set");

    read_live_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        pend_read_s |=> s_axi_rvalid && s_axi_rdata == $past(pend & IMPL_MASK)
                        && s_axi_rresp == RESP_OKAY)
        else $error("read did not return pending state");

    force_sets_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        force_write_s |=> (pend & $past(force_vec & enable_q)) == $past(force_vec & enable_q))
        else $error("force write did not set pending");

    disabled_force_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        force_write_s |=> (pend & ~$past(pend) & ~$past(enable_q)) == 32'h0000_0000)
        else $error("disabled source became pending");

    function automatic logic pend_changed_only_clear(input logic [31:0] now, input logic [31:0] was,
                                                     input logic [31:0] clr, input logic [31:0] tk);
        return ((was & ~now) & ~(clr | tk)) == 32'h0000_0000;
    endfunction : pend_changed_only_clear

    bit_map_a : assert property (@(posedge ref_clk) disable iff (!resetn)
        clear_write_s ##1 (1'b1) |-> (pend_changed_only_clear(pend, $past(pend), $past(clear_vec),
                                      $past(irq_taken))))
        else $error("clear reached another source");
endmodule : irq_clear_pending_bank1
`default_nettype wire

/* hdl/irq_pending_pkg.sv */
package irq_pending_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_SRC         = 32;
    // register byte offsets
    localparam logic [7:0]  PEND_CLEAR_OFS  = 8'h00;
    localparam logic [7:0]  PEND_FORCE_OFS  = 8'h04;
    localparam logic [7:0]  ENABLE_OFS      = 8'h08;
    localparam logic [7:0]  ACTIVE_OFS      = 8'h0c;
    // bits 31 and 13 have no source
    localparam logic [31:0] IMPL_MASK       = 32'h7fff_dfff;
    localparam logic [31:0] PEND_RESET      = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : irq_pending_pkg

/* hdl/pending_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module pending_cell
    import irq_pending_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic enable,
    input  wire logic hw_req,
    input  wire logic sw_force,
    input  wire logic sw_clear,
    input  wire logic active,
    input  wire logic taken,
    output var  logic pending_q
);
    logic pending_d;

    always_comb begin
        pending_d = pending_q;
        if (sw_clear && !active) begin
            pending_d = 1'b0;
        end
        if (taken) begin
            pending_d = 1'b0;
        end
        // a new request wins over a clear in the same cycle
        if ((sw_force || hw_req) && enable) begin
            pending_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
        end
    end
endmodule : pending_cell
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import irq_pending_pkg::*;;
    logic              ref_clk = 1'b0;
    logic              resetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0]        wstrb = '0;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0,
                       rready = 1'b0, snap = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       irq_req = '0, irq_active = '0, irq_taken = '0, pending_out;
    logic [31:0]       seed = 32'hfd5c2412, p, r, c, a, en;
    logic [33:0]       exp_rd[$];
    logic [1:0]        exp_b[$];
    logic [31:0]       exp_pend[$];
    int                errors = 0, compares = 0, cycles = 0;

    irq_clear_pending_bank1 i_dut (.ref_clk(ref_clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq_req(irq_req), .irq_active(irq_active), .irq_taken(irq_taken),
        .pending_out(pending_out));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_resp

    task automatic print_verdict();
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] st,
                             input logic [1:0] rs);
        logic aw_ok, w_ok, b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        exp_b.push_back(rs);
        awaddr <= ad;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= st;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_ok) begin
            @(posedge ref_clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                b_ok = 1'b1;
                bready <= 1'b0;
            end
        end
        @(posedge ref_clk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] rs);
        logic ar_ok, r_ok;
        ar_ok = 1'b0;
        r_ok = 1'b0;
        exp_rd.push_back({rs, d});
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_ok) begin
            @(posedge ref_clk);
            if (!ar_ok && arready === 1'b1) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                r_ok = 1'b1;
                rready <= 1'b0;
            end
        end
        @(posedge ref_clk);
    endtask : axi_read

    task automatic note_pend();
        repeat (2) @(posedge ref_clk);
        exp_pend.push_back(p);
        snap <= 1'b1;
        @(posedge ref_clk);
        snap <= 1'b0;
    endtask : note_pend

    // result watcher: oldest note against each answer
    always @(posedge ref_clk) begin
        if (rvalid === 1'b1 && rready) begin
            check_word(rdata, exp_rd[0][31:0]);
            check_resp(rresp, exp_rd[0][33:32]);
            void'(exp_rd.pop_front());
        end
        if (bvalid === 1'b1 && bready) check_resp(bresp, exp_b.pop_front());
        if (snap) check_word(pending_out, exp_pend.pop_front());
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        p = PEND_RESET;
        en = 32'hffff_ffff;
        axi_read(PEND_CLEAR_OFS, p, RESP_OKAY);
        axi_read(ENABLE_OFS, ENABLE_RESET, RESP_OKAY);
        axi_write(ENABLE_OFS, en, 4'hf, RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            irq_req <= r;
            @(posedge ref_clk);
            irq_req <= '0;
            p = p | (r & en & IMPL_MASK);
            note_pend();
            axi_write(PEND_CLEAR_OFS, 32'h0, 4'hf, RESP_OKAY);
            axi_write(PEND_CLEAR_OFS, ~IMPL_MASK, 4'hf, RESP_OKAY);
            axi_read(PEND_CLEAR_OFS, p, RESP_OKAY);
            a = rnd();
            c = rnd();
            irq_active <= a;
            axi_write(PEND_CLEAR_OFS, c, 4'hf, RESP_OKAY);
            irq_active <= '0;
            p = p & ~(c & ~a);
            axi_read(PEND_CLEAR_OFS, p, RESP_OKAY);
            c = rnd();
            en = rnd();
            axi_write(ENABLE_OFS, en, 4'hf, RESP_OKAY);
            axi_write(PEND_FORCE_OFS, c, 4'hf, RESP_OKAY);
            p = p | (c & en & IMPL_MASK);
            axi_read(PEND_FORCE_OFS, p, RESP_OKAY);
            axi_write(PEND_CLEAR_OFS, 32'hffff_ffff, r[3:0], RESP_OKAY);
            p = p & ~{{8{r[3]}}, {8{r[2]}}, {8{r[1]}}, {8{r[0]}}};
            axi_read(PEND_CLEAR_OFS, p, RESP_OKAY);
            axi_write(PEND_FORCE_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
            p = p | (en & IMPL_MASK);
            irq_taken <= a;
            @(posedge ref_clk);
            irq_taken <= '0;
            p = p & ~a;
            note_pend();
        end
        axi_read(8'h40, 32'h0, RESP_SLVERR);
        axi_write(8'h40, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        axi_read(ENABLE_OFS, en & IMPL_MASK, RESP_OKAY);
        irq_active <= a;
        axi_read(ACTIVE_OFS, a & IMPL_MASK, RESP_OKAY);
        axi_write(ACTIVE_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        irq_active <= '0;
        axi_read(PEND_CLEAR_OFS, p, RESP_OKAY);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
